// *** hdl/asr_host.sv ***
// Host controller driving the asynchronous ECC static memory pins
`timescale 1ns/1ps
`default_nettype none
module asr_host (
   input wire logic mclk_i,
   input wire logic nrst_i,
   // User request side
   input wire logic req_i,
   input wire logic req_wr_i,
   input wire logic [asr_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [1:0] req_lane_n_i,
   input wire logic [asr_pkg::DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   output logic rd_valid_o,
   output logic [asr_pkg::DATA_W-1:0] rd_data_o,
   output logic rd_err_o,
   output logic wr_done_o,
   // Memory pins
   output logic [asr_pkg::ADDR_W-1:0] mem_addr_o,
   output logic chip_sel_n_o,
   output logic out_en_n_o,
   output logic wr_strobe_n_o,
   output logic byte_low_sel_n_o,
   output logic byte_high_sel_n_o,
   output logic [asr_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_o,
   input wire logic [asr_pkg::DATA_W-1:0] mem_data_i,
   input wire logic mem_err_i
);
   typedef struct packed {
      asr_pkg::asr_state_t st;
      logic [3:0] cnt;
      logic [asr_pkg::ADDR_W-1:0] addr;
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic [1:0] lane_n;
      logic [asr_pkg::DATA_W-1:0] wdata;
      logic doe;
      logic ready;
      logic rvalid;
      logic [asr_pkg::DATA_W-1:0] rdata;
      logic rerr;
      logic wdone;
      logic [asr_pkg::DATA_W-1:0] din1;
      logic [asr_pkg::DATA_W-1:0] din2;
      logic err1;
      logic err2;
   } asr_regs_t;

   asr_regs_t r;
   asr_regs_t next_r;

   // Sequencer; pins always hold defined levels, data bus released (mem_data_oe_o low) when idle
   always_comb
   begin
      next_r = r;
      next_r.rvalid = 1'b0;
      next_r.wdone = 1'b0;
      // Two-flop sync of pin inputs, first stage read only by second
      next_r.din1 = mem_data_i;
      next_r.din2 = r.din1;
      next_r.err1 = mem_err_i;
      next_r.err2 = r.err1;
      case (r.st)
         asr_pkg::ASR_IDLE:
         begin
            next_r.ready = 1'b1;
            if (req_i && r.ready && (req_lane_n_i != asr_pkg::LANES_OFF))
            begin
               next_r.ready = 1'b0;
               next_r.addr = req_addr_i;
               next_r.lane_n = req_lane_n_i;
               next_r.wdata = req_wdata_i;
               next_r.cs_n = 1'b0;
               if (req_wr_i)
               begin
                  // Address and data settle one cycle before the strobe
                  next_r.oe_n = 1'b1;
                  next_r.doe = 1'b1;
                  next_r.st = asr_pkg::ASR_SETUP;
               end
               else
               begin
                  next_r.oe_n = 1'b0;
                  next_r.doe = 1'b0;
                  next_r.cnt = asr_pkg::RD_CNT;
                  next_r.st = asr_pkg::ASR_READ;
               end
            end
         end
         asr_pkg::ASR_SETUP:
         begin
            next_r.we_n = 1'b0;
            next_r.cnt = asr_pkg::WR_LOW_CNT;
            next_r.st = asr_pkg::ASR_WRITE;
         end
         asr_pkg::ASR_WRITE:
         begin
            if (r.cnt == 4'h1)
            begin
               // Strobe rises first and ends the write; data held after
               next_r.we_n = 1'b1;
               next_r.st = asr_pkg::ASR_WHOLD;
            end
            next_r.cnt = r.cnt - 4'h1;
         end
         asr_pkg::ASR_WHOLD:
         begin
            next_r.doe = 1'b0;
            next_r.cs_n = 1'b1;
            next_r.lane_n = asr_pkg::LANES_OFF;
            next_r.wdone = 1'b1;
            next_r.st = asr_pkg::ASR_IDLE;
         end
         asr_pkg::ASR_READ:
         begin
            // Extra cycles cover the two-flop synchroniser latency
            if (r.cnt == asr_pkg::CNT_ZERO)
               next_r.st = asr_pkg::ASR_RSAMP;
            else
               next_r.cnt = r.cnt - 4'h1;
         end
         asr_pkg::ASR_RSAMP:
         begin
            if (r.cnt == asr_pkg::CNT_ZERO)
               next_r.cnt = 4'h2;
            else if (r.cnt == 4'h1)
            begin
               // Data and flag captured together, unused lane masked
               next_r.rdata[7:0] = r.lane_n[0] ? 8'h00 : r.din2[7:0];
               next_r.rdata[15:8] = r.lane_n[1] ? 8'h00 : r.din2[15:8];
               next_r.rerr = r.err2;
               next_r.rvalid = 1'b1;
               next_r.oe_n = 1'b1;
               next_r.cs_n = 1'b1;
               next_r.lane_n = asr_pkg::LANES_OFF;
               next_r.st = asr_pkg::ASR_IDLE;
               next_r.cnt = asr_pkg::CNT_ZERO;
            end
            else
               next_r.cnt = r.cnt - 4'h1;
         end
         default:
            next_r.st = asr_pkg::ASR_IDLE;
      endcase
   end

   // State register; inactive pin levels after reset
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r <= '0;
         r.st <= asr_pkg::ASR_IDLE;
         r.cs_n <= 1'b1;
         r.oe_n <= 1'b1;
         r.we_n <= 1'b1;
         r.lane_n <= asr_pkg::LANES_OFF;
      end
      else
         r <= next_r;
   end

   assign req_ready_o = r.ready;
   assign rd_valid_o = r.rvalid;
   assign rd_data_o = r.rdata;
   assign rd_err_o = r.rerr;
   assign wr_done_o = r.wdone;
   assign mem_addr_o = r.addr;
   assign chip_sel_n_o = r.cs_n;
   assign out_en_n_o = r.oe_n;
   assign wr_strobe_n_o = r.we_n;
   assign byte_low_sel_n_o = r.lane_n[0];
   assign byte_high_sel_n_o = r.lane_n[1];
   assign mem_data_o = r.wdata;
   assign mem_data_oe_o = r.doe;

   // Host never drives data while output enable is low
   AST_NO_CONTENTION: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !(r.doe && !r.oe_n)) else $error("host drives data during read");
   // Strobe low only with select and a lane low
   AST_WRITE_OVERLAP: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !r.we_n |-> (!r.cs_n && r.lane_n != 2'h3 && r.doe))
      else $error("strobe low outside write window");
   // Data driven and stable while strobe low and one cycle after rise
   AST_DATA_HOLD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(r.we_n) |-> r.doe && $stable(r.wdata) && !r.cs_n)
      else $error("write data not held at write end");
   // Strobe low time meets setup plus float delay; checked at the rise
   AST_STROBE_WIDTH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(r.we_n) |-> !$past(r.we_n, asr_pkg::WR_LOW_CYC)
      && (asr_pkg::WR_LOW_CYC * asr_pkg::CLK_PERIOD_NS
      >= asr_pkg::DATA_SETUP_TIME_NS + asr_pkg::STROBE_LOW_TO_FLOAT_DELAY_NS))
      else $error("strobe pulse too short");
   // Deselect follows every write one cycle after the strobe rises
   AST_DESELECT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(r.we_n) |-> ##1 r.cs_n && r.lane_n == 2'h3 && !r.doe)
      else $error("memory not deselected after write");
   // Read data valid pulse carries flag captured with data
   AST_READ_DONE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      r.rvalid |-> $past(r.st) == asr_pkg::ASR_RSAMP && r.oe_n && r.rerr == $past(r.err2))
      else $error("error flag not taken with read data");
   // Masked lane reads back zero
   AST_LANE_MASK: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      r.rvalid |-> ($past(r.lane_n[0]) ? r.rdata[7:0] == 8'h00 : 1'b1)
      && ($past(r.lane_n[1]) ? r.rdata[15:8] == 8'h00 : 1'b1))
      else $error("unselected lane not masked");
   // Read completes within bounded time of output enable falling
   AST_READ_BOUND: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(r.oe_n) |-> ##[1:12] r.rvalid)
      else $error("read did not complete");
   // Lane select unchanged and output enable high when the write strobe falls
   AST_WRITE_LANE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(r.we_n) |-> $stable(r.lane_n) && r.oe_n)
      else $error("lane changed at write start");
endmodule
`default_nettype wire

// *** hdl/asr_pkg.sv ***
// Constants for the asynchronous ECC memory host controller
package asr_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 40;
   // Data setup to write end and strobe-low-to-float delay, in ns (slow grade)
   localparam int DATA_SETUP_TIME_NS = 8;
   localparam int STROBE_LOW_TO_FLOAT_DELAY_NS = 8;
   // Address to data valid, longest access, in ns
   localparam int ACCESS_TIME_NS = 15;
   // Least strobe low time rounds up, never below one cycle
   localparam int WR_LOW_RAW =
      (DATA_SETUP_TIME_NS + STROBE_LOW_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_LOW_CYC = (WR_LOW_RAW < 1) ? 1 : WR_LOW_RAW;
   localparam int RD_RAW = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC = (RD_RAW < 1) ? 1 : RD_RAW;
   localparam logic [3:0] WR_LOW_CNT = 4'(WR_LOW_CYC);
   localparam logic [3:0] RD_CNT = 4'(RD_CYC);
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [1:0] LANES_OFF = 2'h3;
   typedef enum {ASR_IDLE, ASR_SETUP, ASR_WRITE, ASR_WHOLD, ASR_READ, ASR_RSAMP} asr_state_t;
endpackage

// *** verif/asr_mem_model.sv ***
// Behavioural model of the ECC static memory on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model (
   input wire logic [17:0] addr_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic bl_n_i,
   input wire logic bh_n_i,
   input wire logic [15:0] din_i,
   input wire logic din_oe_i,
   input wire logic err_set_i,
   output logic [15:0] dout_o,
   output logic err_o,
   output logic clash_o
);
   logic [15:0] mem [0:262143];
   logic [15:0] word, wlat;
   logic [1:0] llat;
   logic rd_act, wr_act;
   initial clash_o = 1'b0;
   // Write window needs all three low; first rise closes it
   assign wr_act = !cs_n_i && !we_n_i && !(bl_n_i && bh_n_i);
   assign rd_act = !cs_n_i && !oe_n_i && we_n_i && !(bl_n_i && bh_n_i);
   assign word = mem[addr_i];
   // Data is taken as it stands at the closing edge
   always @* if (wr_act) {llat, wlat} = {bh_n_i, bl_n_i, din_i};
   always @(negedge wr_act)
      mem[addr_i] = {llat[1] ? word[15:8] : wlat[15:8], llat[0] ? word[7:0] : wlat[7:0]};
   // Floating lanes show the inverse so a stale value cannot pass
   assign dout_o[7:0] = (rd_act && !bl_n_i) ? word[7:0] : ~word[7:0];
   assign dout_o[15:8] = (rd_act && !bh_n_i) ? word[15:8] : ~word[15:8];
   assign err_o = rd_act ? err_set_i : ~err_set_i;
   // Sticky contention flag, host driving while memory drives
   always @* if (rd_act && din_oe_i) clash_o = 1'b1;
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the ECC memory host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk_i = 1'b0, nrst_i = 1'b0, req_i = 1'b0, req_wr_i = 1'b0, err_set = 1'b0;
   logic [17:0] req_addr_i = 18'h00000;
   logic [1:0] req_lane_n_i = 2'h3;
   logic [15:0] req_wdata_i = 16'h0000;
   logic req_ready_o, rd_valid_o, rd_err_o, wr_done_o, chip_sel_n_o, out_en_n_o, wr_strobe_n_o;
   logic byte_low_sel_n_o, byte_high_sel_n_o, mem_data_oe_o, mem_err_i, clash;
   logic [15:0] rd_data_o, mem_data_o, mem_data_i;
   logic [17:0] mem_addr_o;
   int bad_count = 0, cmp_count = 0;
   always #20 mclk_i = ~mclk_i;
   asr_host uut (.mclk_i, .nrst_i, .req_i, .req_wr_i, .req_addr_i, .req_lane_n_i, .req_wdata_i,
      .req_ready_o, .rd_valid_o, .rd_data_o, .rd_err_o, .wr_done_o, .mem_addr_o, .chip_sel_n_o,
      .out_en_n_o, .wr_strobe_n_o, .byte_low_sel_n_o, .byte_high_sel_n_o, .mem_data_o,
      .mem_data_oe_o, .mem_data_i, .mem_err_i);
   asr_mem_model mem (.addr_i(mem_addr_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o),
      .we_n_i(wr_strobe_n_o), .bl_n_i(byte_low_sel_n_o), .bh_n_i(byte_high_sel_n_o),
      .din_i(mem_data_o), .din_oe_i(mem_data_oe_o), .err_set_i(err_set), .dout_o(mem_data_i),
      .err_o(mem_err_i), .clash_o(clash));
   task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Request held until the edge that sees ready, then cycles to the answer
   task automatic xfer(input logic wr, input logic [17:0] a, input logic [1:0] ln,
      input logic [15:0] d, output int k);
      logic rdy;
      @(posedge mclk_i);
      {req_i, req_wr_i, req_addr_i, req_lane_n_i, req_wdata_i} <= {1'b1, wr, a, ln, d};
      k = 0;
      // Ready read settled before the edge that takes it, never in the launch step
      do
      begin
         #1;
         rdy = req_ready_o;
         @(posedge mclk_i);
         k++;
      end
      while (rdy !== 1'b1 && k < 20);
      req_i <= 1'b0;
      k = 0;
      do begin @(posedge mclk_i); #1; k++; end while ((wr ? wr_done_o : rd_valid_o) !== 1'b1 && k < 12);
   endtask
   // Write one lane pattern, read back another, check latencies too
   task automatic wr_rd(input logic [17:0] a, input logic [1:0] wl, input logic [15:0] wd,
      input logic [1:0] rl, input logic [15:0] exp);
      int k;
      xfer(1'b1, a, wl, wd, k);
      // Both lanes off is refused: no done pulse, the wait runs out at 12
      chk("wr_lat", 18'(k), (wl == 2'h3) ? 18'h0000C : 18'(asr_pkg::WR_LOW_CYC + 2));
      xfer(1'b0, a, rl, 16'h0000, k);
      chk("rd_lat", 18'(k), 18'(asr_pkg::RD_CYC + 4));
      chk("rd_data", rd_data_o, exp);
      chk("rd_err", rd_err_o, err_set);
   endtask
   task t_word;
      wr_rd(18'h00155, 2'h0, 16'hBEEF, 2'h0, 16'hBEEF);
      $display("test word done");
   endtask
   task t_low;
      wr_rd(18'h00155, 2'h2, 16'h1234, 2'h2, 16'h0034);
      wr_rd(18'h00155, 2'h3, 16'h0000, 2'h0, 16'hBE34);
      $display("test low lane done");
   endtask
   task t_high;
      wr_rd(18'h00155, 2'h1, 16'h5678, 2'h1, 16'h5600);
      wr_rd(18'h00155, 2'h3, 16'h0000, 2'h0, 16'h5634);
      $display("test high lane done");
   endtask
   // Both lanes off must start nothing at the pins
   task t_off;
      @(posedge mclk_i);
      {req_i, req_wr_i, req_lane_n_i} <= {1'b1, 1'b1, 2'h3};
      repeat (8)
      begin
         @(posedge mclk_i);
         #1;
         chk("off_cs", {req_ready_o, wr_done_o, mem_data_oe_o, chip_sel_n_o}, 4'h9);
      end
      req_i <= 1'b0;
      $display("test lanes off done");
   endtask
   // Mid-run reset puts every control pin at its idle level, ready one edge after release
   task t_rst;
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      chk("rst_pins", {req_ready_o, chip_sel_n_o, out_en_n_o, wr_strobe_n_o, byte_low_sel_n_o,
         byte_high_sel_n_o, mem_data_oe_o}, 7'h3E);
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      #1;
      chk("rst_ready0", req_ready_o, 1'b0);
      @(posedge mclk_i);
      #1;
      chk("rst_ready1", req_ready_o, 1'b1);
      $display("test mid reset done");
   endtask
   task t_err;
      err_set = 1'b1;
      wr_rd(18'h3FFFF, 2'h0, 16'hA55A, 2'h0, 16'hA55A);
      err_set = 1'b0;
      chk("clash", clash, 18'h00000);
      $display("test error flag done");
   endtask
   initial
   begin
      #100000;
      bad_count++;
      stop_test;
   end
   initial
   begin
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_word;
      t_low;
      t_high;
      t_off;
      t_rst;
      t_err;
      stop_test;
   end
endmodule
`default_nettype wire
